// >>> pkg/rcto_map.vh
// Purpose: constants for the calibration and test-output block
// Assumes: 8-bit control register at serial address 7
// Notes:   bit positions, reset value and divider counts
`ifndef RCTO_MAP_VH
`define RCTO_MAP_VH

// register address and reset value
`define RCTO_CTRL_ADDR      3'h7
`define RCTO_CTRL_RESET     8'h80

// control register fields
`define RCTO_MAG_MSB        4
`define RCTO_MAG_LSB        0
`define RCTO_SIGN_BIT       5
`define RCTO_FT_BIT         6
`define RCTO_OUT_BIT        7

// divider chain
`define RCTO_STAGE1_MAX     8'hff
`define RCTO_STAGE1_SKIP    8'h80
`define RCTO_STAGE2_MAX     7'h7f
`define RCTO_TEST_HALF_MAX  5'h1f
`define RCTO_SEC_MAX        6'h3b
`define RCTO_CYCLE_MAX      6'h3f
`define RCTO_CYCLE_ELIGIBLE 6'h3e
`define RCTO_CORR_SECOND    6'h00

// sys clocks without an oscillator edge before the pin is released in test mode
`define RCTO_ALIVE_MAX      8'hff

`endif

// >>> verilog/rcto_top.v
// Purpose: digital calibration and open-drain test/level output of an rtc
// Assumes: 32768 Hz oscillator arrives as a pin and is sampled on sys_clk_i
// Notes:   one second pulse per corrected or plain second is sent out
//
// Operation
// RULE1: calibration adds or removes counts at the divide-by-256 stage only.
// RULE2: control bits 4..0 hold calibration magnitude 0 to 31.
// RULE3: control bit 5 chooses sign: one lengthens, zero shortens seconds.
// RULE4: 64-minute cycle; first 62 minutes eligible; one second per minute.
// RULE5: negative shortens second by 128 cycles; positive lengthens by 256.
// RULE6: magnitude N corrects exactly the first 2N minutes of the cycle.
// RULE7: test bit set and oscillator running toggles the pin at 512 Hz.
// RULE8: 512 Hz output taken before correction, unaffected by calibration.
// RULE9: test bit clear drives the pin from control bit 7; zero pulls low.
// RULE10: pin is open drain: only pulled low, otherwise released.
// RULE11: at power-up test bit clears to zero and level bit sets to one.
// RULE12: control register at address 7 is reachable on its own.
// RULE13: cycle advances on own minute rollovers; one fixed second corrected.
`timescale 1ns/1ps
`include "rcto_map.vh"

module rcto_top
(
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // oscillator pin
  input  wire       osc_clk_i,
  // register port from the serial slave
  input  wire [2:0] reg_addr_i,
  input  wire       reg_we_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // timekeeping strobe
  output reg        sec_tick_o,
  // shared open-drain pin
  output reg        test_or_level_pin_o,
  output reg        test_or_level_pin_oe_o
);

  // address decode shared by write and read paths
  function is_ctrl_addr;
    input [2:0] addr;
    begin
      is_ctrl_addr = (addr == `RCTO_CTRL_ADDR);
    end
  endfunction

  reg  [7:0] calibration_and_output_control;
  reg        osc_sync1;
  reg        osc_sync2;
  reg        osc_prev;
  reg  [7:0] stage1;
  reg  [6:0] stage2;
  reg  [5:0] sec_cnt;
  reg  [5:0] cycle_pos;
  reg        corr_done;
  reg        split_pend;
  reg  [4:0] test_cnt;
  reg        test_wave;
  reg        osc_alive;
  reg  [7:0] alive_cnt;
  reg  [7:0] next_stage1;
  reg        stage1_carry;
  reg        do_corr;

  wire       osc_edge;
  wire [4:0] cal_mag;
  wire       cal_sign;
  wire       freq_test_enable;
  wire       out_level;
  wire [6:0] corr_minutes;
  wire       minute_eligible;

  assign osc_edge         = osc_sync2 & ~osc_prev;
  assign cal_mag          = calibration_and_output_control[`RCTO_MAG_MSB:`RCTO_MAG_LSB];
  assign cal_sign         = calibration_and_output_control[`RCTO_SIGN_BIT];
  assign freq_test_enable = calibration_and_output_control[`RCTO_FT_BIT];
  assign out_level        = calibration_and_output_control[`RCTO_OUT_BIT];

  // RULE6: first 2N minutes
  assign corr_minutes     = {1'b0, cal_mag, 1'b0};
  // RULE4: only first 62 minutes
  assign minute_eligible  = ({1'b0, cycle_pos} < corr_minutes) &&
                            (cycle_pos < `RCTO_CYCLE_ELIGIBLE);

  // oscillator pin synchroniser
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev  <= 1'b0;
    end
    else
    begin
      osc_sync1 <= osc_clk_i;
      osc_sync2 <= osc_sync1;
      osc_prev  <= osc_sync2;
    end
  end

  // RULE12: control register alone at its address
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      // RULE11: test bit low, level bit high
      calibration_and_output_control <= `RCTO_CTRL_RESET;
      reg_rdata_o                    <= 8'h00;
    end
    else
    begin
      // RULE2: magnitude and control bits stored
      if (reg_we_i && is_ctrl_addr(reg_addr_i))
        calibration_and_output_control <= reg_wdata_i;
      if (is_ctrl_addr(reg_addr_i))
        reg_rdata_o <= calibration_and_output_control;
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // corrected second is a fixed second of an eligible minute
  always @*
  begin
    do_corr = minute_eligible && !corr_done && (sec_cnt == `RCTO_CORR_SECOND) &&
              (cal_mag != 5'h00);
  end

  // RULE1: correction at the divide-by-256 stage
  always @*
  begin
    next_stage1  = stage1 + 8'h01;
    stage1_carry = (stage1 == `RCTO_STAGE1_MAX);
    if (stage1_carry && do_corr && !cal_sign)
      // RULE5: blanking skips 128 counts
      next_stage1 = `RCTO_STAGE1_SKIP;
  end

  // divider chain, seconds, minutes and 64-minute cycle
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      stage1     <= 8'h00;
      stage2     <= 7'h00;
      sec_cnt    <= 6'h00;
      cycle_pos  <= 6'h00;
      corr_done  <= 1'b0;
      split_pend <= 1'b0;
      sec_tick_o <= 1'b0;
    end
    else
    begin
      sec_tick_o <= 1'b0;
      if (osc_edge)
      begin
        stage1 <= next_stage1;
        if (stage1_carry)
        begin
          if (do_corr)
          begin
            corr_done <= 1'b1;
            // RULE3: sign picks lengthen or shorten
            if (cal_sign)
              split_pend <= 1'b1;
          end
          if (split_pend)
            // RULE5: split pulse adds 256 cycles
            split_pend <= 1'b0;
          else if (stage2 == `RCTO_STAGE2_MAX)
          begin
            stage2     <= 7'h00;
            sec_tick_o <= 1'b1;
            if (sec_cnt == `RCTO_SEC_MAX)
            begin
              sec_cnt   <= 6'h00;
              corr_done <= 1'b0;
              // RULE13: cycle steps on own minute rollover
              if (cycle_pos == `RCTO_CYCLE_MAX)
                cycle_pos <= 6'h00;
              else
                cycle_pos <= cycle_pos + 6'h01;
            end
            else
              sec_cnt <= sec_cnt + 6'h01;
          end
          else
            stage2 <= stage2 + 7'h01;
        end
      end
    end
  end

  // RULE8: 512 Hz taken straight from the oscillator
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      test_cnt  <= 5'h00;
      test_wave <= 1'b1;
    end
    else if (osc_edge)
    begin
      test_cnt <= test_cnt + 5'h01;
      if (test_cnt == `RCTO_TEST_HALF_MAX)
        test_wave <= ~test_wave;
    end
  end

  // oscillator running detector, times out after 256 sys clocks without edge
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      alive_cnt <= 8'h00;
      osc_alive <= 1'b0;
    end
    else if (osc_edge)
    begin
      alive_cnt <= 8'h00;
      osc_alive <= 1'b1;
    end
    else if (alive_cnt == `RCTO_ALIVE_MAX)
      osc_alive <= 1'b0;
    else
      alive_cnt <= alive_cnt + 8'h01;
  end

  // shared pin drive
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      test_or_level_pin_o    <= 1'b0;
      test_or_level_pin_oe_o <= 1'b0;
    end
    else
    begin
      // RULE10: only ever drives low
      test_or_level_pin_o <= 1'b0;
      if (freq_test_enable)
        // RULE7: square wave while oscillator runs
        test_or_level_pin_oe_o <= osc_alive & ~test_wave;
      else
        // RULE9: level bit, zero pulls low
        test_or_level_pin_oe_o <= ~out_level;
    end
  end

endmodule

// >>> sim/rcto_top_checker.sv
// Purpose: port assertions for rcto_top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every rcto_top
`timescale 1ns/1ps
module rcto_checker
(
  input wire       sys_clk_i,
  input wire       rst_n_i,
  input wire [2:0] reg_addr_i,
  input wire       reg_we_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       sec_tick_o,
  input wire       test_or_level_pin_o,
  input wire       test_or_level_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wr7 = reg_we_i && reg_addr_i == 3'h7;
  AST_PIN_LOW: assert property (test_or_level_pin_o == 1'b0)
    else $error("pin data not low");
  AST_READ_OTHER: assert property (reg_addr_i != 3'h7 |=> reg_rdata_o == 8'h00)
    else $error("other address read not zero");
  AST_READ_BACK: assert property (wr7 ##1 reg_addr_i == 3'h7 |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback wrong");
  AST_RDATA_HOLD: assert property ((reg_addr_i == 3'h7 && !reg_we_i) [*2] |=>
    $stable(reg_rdata_o)) else $error("read data moved");
  AST_LEVEL_LOW: assert property (wr7 && reg_wdata_i[7:6] == 2'b00 ##1 !wr7 |=>
    test_or_level_pin_oe_o) else $error("pin not pulled low");
  AST_LEVEL_FREE: assert property (wr7 && reg_wdata_i[7:6] == 2'b10 ##1 !wr7 |=>
    !test_or_level_pin_oe_o) else $error("pin not released");
  AST_RESET_OUT: assert property ($rose(rst_n_i) |->
    !test_or_level_pin_oe_o && reg_rdata_o == 8'h00) else $error("reset outputs wrong");
  AST_TICK_ONE: assert property (sec_tick_o |=> !sec_tick_o)
    else $error("second tick too long");
  COV_FT: cover property (wr7 && reg_wdata_i[6]);
  COV_RISE: cover property ($rose(test_or_level_pin_oe_o));
  COV_FALL: cover property ($fell(test_or_level_pin_oe_o));
  COV_TICK: cover property (sec_tick_o);
endmodule
bind rcto_top rcto_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .sec_tick_o(sec_tick_o), .test_or_level_pin_o(test_or_level_pin_o),
  .test_or_level_pin_oe_o(test_or_level_pin_oe_o));

// >>> sim/rcto_tb_top.sv
// Purpose: self-checking bench for rcto_top
// Assumes: oscillator sped up to 4 sys clocks a period, 2 for the second run
// Notes:   only the first, corrected second after a reset is timed
`timescale 1ns/1ps
module rcto_tb_top;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        osc_run = 1'b0;
  reg        fast = 1'b0;
  wire       tick;
  integer    rises = 0;
  reg  [1:0] osc = 2'h0;
  reg  [2:0] addr = 3'h0;
  reg        we = 1'b0;
  reg  [7:0] wd = 8'h00;
  reg  [7:0] d;
  wire [7:0] rdata;
  wire       pin;
  wire       oe;
  integer    miscompares = 0;
  integer    checks_done = 0;
  integer    seed = 32'h08cb373c;
  integer    ctrl_m = 8'h80;
  integer    i;
  integer    n;
  always #12.5 clk = ~clk;
  always @(negedge clk) if (osc_run) osc <= osc + {fast, ~fast};
  always @(posedge osc[1]) rises = rises + 1;
  rcto_top u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .osc_clk_i(osc[1]), .reg_addr_i(addr),
    .reg_we_i(we), .reg_wdata_i(wd), .reg_rdata_o(rdata), .sec_tick_o(tick),
    .test_or_level_pin_o(pin), .test_or_level_pin_oe_o(oe));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    begin
      addr = a;
      we = 1'b1;
      wd = v;
      @(negedge clk);
      we = 1'b0;
      if (a == 3'h7) ctrl_m = v;
    end
  endtask
  task rd(input [2:0] a);
    begin
      addr = a;
      @(negedge clk);
      chk(rdata, (a == 3'h7) ? ctrl_m : 0);
    end
  endtask
  // cycles until the pin enable next changes
  task span(output integer c);
    reg p;
    begin
      p = oe;
      for (c = 0; c < 400 && oe === p; c = c + 1)
        @(negedge clk);
    end
  endtask
  task final_report;
    begin
      if (miscompares == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rd(3'h7);
    chk(oe, 0);
    for (i = 0; i < 24; i = i + 1)
    begin
      d = $random(seed);
      wr(i[0] ? 3'h7 : d[2:0], d & 8'hbf);
      rd(3'h7);
      rd(d[5:3]);
      chk(oe, !ctrl_m[7]);
    end
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    ctrl_m = 8'h80;
    rd(3'h7);
    osc_run = 1'b1;
    wr(3'h7, 8'h40 | (d & 8'h3f));
    repeat (3) span(n);
    chk(n, 128);
    wr(3'h7, 8'h60 ^ (d & 8'h1f));
    repeat (2) span(n);
    chk(n, 128);
    osc_run = 1'b0;
    repeat (300) @(negedge clk);
    chk(oe, 0);
    osc = 2'h0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    wr(3'h7, 8'h01);
    fast = 1'b1;
    rises = 0;
    osc_run = 1'b1;
    for (n = 0; n < 70000 && tick !== 1'b1; n = n + 1)
      @(negedge clk);
    // first second of the cycle is short: 32768 - 128 edges, one more in flight
    chk(rises, 32641);
    final_report;
  end
  initial
  begin
    #(25 * 80000);
    miscompares = miscompares + 1;
    final_report;
  end
endmodule
